// ==== hw/fssc_pkg.sv ====
// fssc_pkg: constants and types for the fieldbus slave state control block
// assumes: single clock domain, shared by the top module and its checker
package fssc_pkg;

  // ==========================================================================
  // slave states (one-hot)
  typedef enum logic [4:0] {
    FSSC_ST_INIT   = 5'h01,
    FSSC_ST_PREOP  = 5'h02,
    FSSC_ST_SAFE_OPERATIONAL_STATE = 5'h04,
    FSSC_ST_OP     = 5'h08,
    FSSC_ST_BOOT   = 5'h10
  } fssc_state_type;

  // ==========================================================================
  // request codes from the master
  localparam logic [2:0] FSSC_REQ_INIT   = 3'h1;
  localparam logic [2:0] FSSC_REQ_PREOP  = 3'h2;
  localparam logic [2:0] FSSC_REQ_BOOT   = 3'h3;
  localparam logic [2:0] FSSC_REQ_SAFE_OPERATIONAL_STATE = 3'h4;
  localparam logic [2:0] FSSC_REQ_OP     = 3'h5;

  // ==========================================================================
  // mailbox protocol codes
  localparam logic [1:0] FSSC_MBX_SDO = 2'h0;
  localparam logic [1:0] FSSC_MBX_FILE = 2'h1;

  // ==========================================================================
  // error codes and fixed figures
  localparam logic [5:0] FSSC_ERR_NONE   = 6'h00;
  localparam logic [5:0] FSSC_ERR_SYNC   = 6'h1C;
  localparam logic [5:0] FSSC_ERR_CONFIG = 6'h1D;
  localparam logic [5:0] FSSC_ERR_TRANS  = 6'h3F;
  localparam int         FSSC_LAYOUTS    = 8;
  localparam int         FSSC_POS_BITS   = 20;
  localparam logic [1:0] FSSC_MISS_LIMIT = 2'h2;
  localparam int         FSSC_DATA_W     = 32;

endpackage : fssc_pkg

// ==== hw/fssc_if.sv ====
// fssc_if: process data path signals between state control and output stage
// assumes: out_en, out_valid, out_data driven by fssc_top for fssc_outstage; drive_data driven back by fssc_outstage
`timescale 1ns/100ps
interface fssc_if;
  import fssc_pkg::*;
  logic                      out_en;
  logic                      out_valid;
  logic [FSSC_DATA_W-1:0]    out_data;
  logic [FSSC_DATA_W-1:0]    drive_data;
  modport ctrl  (output out_en, output out_valid, output out_data, input drive_data);
  modport stage (input out_en, input out_valid, input out_data, output drive_data);
endinterface : fssc_if

// ==== hw/fssc_outstage.sv ====
// fssc_outstage: holds drive outputs safe unless enabled, latches master data
// assumes: out_en already combines state and watchdog decision
`timescale 1ns/100ps
module fssc_outstage
  import fssc_pkg::*;
(
  input  wire logic i_sys_clk,
  input  wire logic i_rstn,
  fssc_if.stage     bus
);
  typedef struct packed {
    logic [FSSC_DATA_W-1:0] out;
  } fssc_os_type;

  fssc_os_type st_q;
  fssc_os_type st_d;

  // ==========================================================================
  // output latch
  always_comb begin
    st_d = st_q;
    if (!bus.out_en) begin
      st_d.out = '0;                    // safe value
    end else if (bus.out_valid) begin
      st_d.out = bus.out_data;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign bus.drive_data = st_q.out;

  safe_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    !bus.out_en |=> (bus.drive_data == '0))
    else $error("outputs not safe while disabled");
endmodule // fssc_outstage

// ==== hw/fssc_top.sv ====
// fssc_top: communication state control of the drive's fieldbus slave
// assumes: master requests and configuration checks arrive synchronous to i_sys_clk
`timescale 1ns/100ps
module fssc_top
  import fssc_pkg::*;
(
  input  wire logic                       i_sys_clk,
  input  wire logic                       i_rstn,
  input  wire logic                       i_req_valid,
  input  wire logic [2:0]                 i_req_state,
  input  wire logic                       i_mbx_cfg_ok,
  input  wire logic                       i_pd_cfg_ok,
  input  wire logic                       i_dc_used,
  input  wire logic                       i_dc_cfg_ok,
  input  wire logic                       i_sync_done,
  input  wire logic                       i_frame_tick,
  input  wire logic                       i_frame_seen,
  input  wire logic                       i_jitter_err,
  input  wire logic                       i_wdog_disable,
  input  wire logic [2:0]                 i_layout_sel,
  input  wire logic                       i_mbx_valid,
  input  wire logic [1:0]                 i_mbx_proto,
  input  wire logic                       i_pd_valid,
  input  wire logic [FSSC_DATA_W-1:0]     i_pd_out_data,
  input  wire logic [FSSC_DATA_W-1:0]     i_in_data,
  input  wire logic [FSSC_POS_BITS-1:0]   i_resolver_pos,
  input  wire logic                       i_fatal_err,
  input  wire logic                       i_nonfatal_err,
  output logic [4:0]                      o_state,
  output logic                            o_ack,
  output logic                            o_err,
  output logic [5:0]                      o_err_code,
  output logic                            o_mbx_accept,
  output logic                            o_pd_accept,
  output logic                            o_in_wr,
  output logic [FSSC_DATA_W-1:0]          o_in_buf_data,
  output logic [FSSC_POS_BITS-1:0]        o_position,
  output logic [2:0]                      o_layout,
  output logic [FSSC_DATA_W-1:0]          o_drive_out,
  output logic                            o_fatal_latched,
  output logic                            o_nonfatal_latched
);
  import fssc_pkg::*;

  typedef struct packed {
    fssc_state_type           state;
    logic                     ack;
    logic                     err;
    logic [5:0]               err_code;
    logic [1:0]               miss_cnt;
    logic                     in_wr;
    logic [FSSC_DATA_W-1:0]   in_buf;
    logic [FSSC_POS_BITS-1:0] pos;
    logic [2:0]               layout;
    logic                     fatal;
    logic                     nonfatal;
  } fssc_top_type;

  fssc_top_type st_q;
  fssc_top_type st_d;
  fssc_if       pd_if ();

  logic in_init;
  logic in_pre;
  logic in_safe;
  logic in_op;
  logic in_boot;
  logic pd_ok;
  logic dc_ok;
  logic sync_fail;

  assign in_init = (st_q.state == FSSC_ST_INIT);
  assign in_pre  = (st_q.state == FSSC_ST_PREOP);
  assign in_safe = (st_q.state == FSSC_ST_SAFE_OPERATIONAL_STATE);
  assign in_op   = (st_q.state == FSSC_ST_OP);
  assign in_boot = (st_q.state == FSSC_ST_BOOT);
  assign dc_ok   = !i_dc_used || i_dc_cfg_ok;
  assign pd_ok   = i_pd_cfg_ok && dc_ok;

  // two missing master data telegrams in a row or jitter
  assign sync_fail = in_op && (i_jitter_err ||
                     (i_frame_tick && !i_frame_seen && (st_q.miss_cnt == FSSC_MISS_LIMIT - 2'h1)));

  // ==========================================================================
  // state machine
  always_comb begin
    st_d          = st_q;
    st_d.ack      = 1'b0;
    st_d.in_wr    = 1'b0;
    st_d.pos      = i_resolver_pos;    // fixed 20-bit per revolution
    if (i_fatal_err) begin
      st_d.fatal = 1'b1;
    end
    if (i_nonfatal_err) begin
      st_d.nonfatal = 1'b1;
    end
    if (in_op && i_frame_tick) begin
      st_d.miss_cnt = i_frame_seen ? 2'h0 : st_q.miss_cnt + 2'h1;
    end
    if (!in_op) begin
      st_d.miss_cnt = 2'h0;
    end
    if (in_safe || in_op) begin
      st_d.in_buf = i_in_data;         // inputs refreshed each cycle
      st_d.in_wr  = 1'b1;
    end
    if (sync_fail) begin
      st_d.state    = FSSC_ST_SAFE_OPERATIONAL_STATE;
      st_d.err      = 1'b1;
      st_d.err_code = FSSC_ERR_SYNC;
      st_d.miss_cnt = 2'h0;
    end else if (i_req_valid) begin
      case (st_q.state)
        FSSC_ST_INIT: begin
          if (i_req_state == FSSC_REQ_PREOP) begin
            if (i_mbx_cfg_ok) begin
              st_d.state    = FSSC_ST_PREOP;
              st_d.ack      = 1'b1;
              st_d.nonfatal = i_nonfatal_err; // soft reset keeps fatal
              st_d.err      = 1'b0;
              st_d.err_code = FSSC_ERR_NONE;
            end else begin
              st_d.err      = 1'b1;
              st_d.err_code = FSSC_ERR_CONFIG;
            end
          end else if (i_req_state == FSSC_REQ_BOOT) begin
            st_d.state = FSSC_ST_BOOT;
            st_d.ack   = 1'b1;
          end else if (i_req_state == FSSC_REQ_INIT) begin
            st_d.ack = 1'b1;
          end else begin
            st_d.err      = 1'b1;
            st_d.err_code = FSSC_ERR_TRANS;
          end
        end
        FSSC_ST_PREOP: begin
          if (i_req_state == FSSC_REQ_SAFE_OPERATIONAL_STATE) begin
            if (pd_ok) begin
              st_d.state  = FSSC_ST_SAFE_OPERATIONAL_STATE;
              st_d.in_buf = i_in_data; // inputs written in the same cycle as ack
              st_d.in_wr  = 1'b1;
              st_d.layout = i_layout_sel; // one of eight layouts
              st_d.ack    = 1'b1;
            end else begin
              st_d.err      = 1'b1;
              st_d.err_code = FSSC_ERR_CONFIG;
            end
          end else if (i_req_state == FSSC_REQ_INIT) begin
            st_d.state = FSSC_ST_INIT;
            st_d.ack   = 1'b1;
          end else if (i_req_state != FSSC_REQ_PREOP) begin
            st_d.err      = 1'b1;
            st_d.err_code = FSSC_ERR_TRANS;
          end
        end
        FSSC_ST_SAFE_OPERATIONAL_STATE: begin
          if (i_req_state == FSSC_REQ_OP) begin
            if (i_sync_done) begin
              st_d.state = FSSC_ST_OP;
              st_d.ack   = 1'b1;
            end else begin
              st_d.err      = 1'b1;
              st_d.err_code = FSSC_ERR_SYNC;
            end
          end else if (i_req_state == FSSC_REQ_PREOP) begin
            st_d.state = FSSC_ST_PREOP;
            st_d.ack   = 1'b1;
          end else if (i_req_state == FSSC_REQ_INIT) begin
            st_d.state = FSSC_ST_INIT;
            st_d.ack   = 1'b1;
          end else if (i_req_state != FSSC_REQ_SAFE_OPERATIONAL_STATE) begin
            st_d.err      = 1'b1;
            st_d.err_code = FSSC_ERR_TRANS;
          end
        end
        FSSC_ST_OP: begin
          if (i_req_state == FSSC_REQ_SAFE_OPERATIONAL_STATE) begin
            st_d.state = FSSC_ST_SAFE_OPERATIONAL_STATE;
            st_d.ack   = 1'b1;
          end else if (i_req_state == FSSC_REQ_PREOP) begin
            st_d.state = FSSC_ST_PREOP;
            st_d.ack   = 1'b1;
          end else if (i_req_state == FSSC_REQ_INIT) begin
            st_d.state = FSSC_ST_INIT;
            st_d.ack   = 1'b1;
          end else if (i_req_state != FSSC_REQ_OP) begin
            st_d.err      = 1'b1;
            st_d.err_code = FSSC_ERR_TRANS;
          end
        end
        FSSC_ST_BOOT: begin
          if (i_req_state == FSSC_REQ_INIT) begin
            st_d.state = FSSC_ST_INIT;
            st_d.ack   = 1'b1;
          end else if (i_req_state != FSSC_REQ_BOOT) begin
            st_d.err      = 1'b1;
            st_d.err_code = FSSC_ERR_TRANS;
          end
        end
        default: begin
          st_d.state = FSSC_ST_INIT;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_q       <= '0;
      st_q.state <= FSSC_ST_INIT;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================================
  // exchange gating
  // mailbox carries only service requests; no cyclic path to parameters
  assign o_mbx_accept = i_mbx_valid && (in_pre || in_safe || in_op ||
                        (in_boot && i_mbx_proto == FSSC_MBX_FILE));
  assign o_pd_accept  = i_pd_valid && (in_safe || in_op);

  // watchdog on unless software disables it
  assign pd_if.out_en    = in_op || (in_safe && i_wdog_disable);
  assign pd_if.out_valid = o_pd_accept;
  assign pd_if.out_data  = i_pd_out_data;

  fssc_outstage u_outstage (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .bus       (pd_if.stage)
  );

  assign o_state            = st_q.state;
  assign o_ack              = st_q.ack;
  assign o_err              = st_q.err;
  assign o_err_code         = st_q.err_code;
  assign o_in_wr            = st_q.in_wr;
  assign o_in_buf_data      = st_q.in_buf;
  assign o_position         = st_q.pos;
  assign o_layout           = st_q.layout;
  assign o_drive_out        = pd_if.drive_data;
  assign o_fatal_latched    = st_q.fatal;
  assign o_nonfatal_latched = st_q.nonfatal;

  // ==========================================================================
  // checks
  sequence boot_req_s;
    i_req_valid && !sync_fail && i_req_state == FSSC_REQ_BOOT;
  endsequence

  init_gate_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    in_init |-> !o_mbx_accept && !o_pd_accept)
    else $error("exchange served in init");
  preop_gate_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    in_pre |-> !o_pd_accept)
    else $error("process data served in preop");
  mbx_check_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    in_init && i_req_valid && i_req_state == FSSC_REQ_PREOP && !i_mbx_cfg_ok
    |=> o_state == FSSC_ST_INIT && o_err_code == FSSC_ERR_CONFIG)
    else $error("bad mailbox setup accepted");
  pd_check_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    in_pre && i_req_valid && i_req_state == FSSC_REQ_SAFE_OPERATIONAL_STATE && !pd_ok |=> o_state == FSSC_ST_PREOP)
    else $error("bad process setup accepted");
  input_copy_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    in_pre && i_req_valid && i_req_state == FSSC_REQ_SAFE_OPERATIONAL_STATE && pd_ok
    |=> o_in_wr && o_in_buf_data == $past(i_in_data) && o_ack)
    else $error("inputs not copied at safe_operational_state entry");
  safe_out_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    in_safe && !i_wdog_disable |-> ##1 o_drive_out == '0)
    else $error("outputs driven under watchdog");
  boot_entry_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    !in_init && !in_boot ##0 boot_req_s |=> o_state != FSSC_ST_BOOT)
    else $error("boot entered from wrong state");
  boot_mbx_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    in_boot && i_mbx_proto != FSSC_MBX_FILE |-> !o_mbx_accept && !o_pd_accept)
    else $error("boot served wrong traffic");
  op_sync_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    in_safe && !i_sync_done |=> o_state != FSSC_ST_OP)
    else $error("op entered before sync");
  sync_fall_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    sync_fail |=> o_state == FSSC_ST_SAFE_OPERATIONAL_STATE && o_err_code == FSSC_ERR_SYNC)
    else $error("no fallback on sync error");
  soft_reset_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    in_init && $past(o_fatal_latched) ##1 in_pre |-> o_fatal_latched)
    else $error("fatal error cleared");
  soft_clear_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    in_init && i_req_valid && !sync_fail && i_req_state == FSSC_REQ_PREOP && i_mbx_cfg_ok
    && !i_nonfatal_err |=> !o_nonfatal_latched)
    else $error("non-fatal errors not cleared");
endmodule // fssc_top

// ==== test/fssc_master_model.sv ====
// fssc_master_model: fieldbus master side, issues state requests, frames, output data
// assumes: bench calls its tasks; everything changes on the falling clock edge
`timescale 1ns/100ps
module fssc_master_model (
  input  wire logic                         i_sys_clk,
  output logic                              o_req_valid,
  output logic [2:0]                        o_req_state,
  output logic                              o_mbx_cfg_ok,
  output logic                              o_pd_cfg_ok,
  output logic                              o_dc_used,
  output logic                              o_dc_cfg_ok,
  output logic                              o_frame_tick,
  output logic                              o_frame_seen,
  output logic                              o_pd_valid,
  output logic [fssc_pkg::FSSC_DATA_W-1:0]  o_pd_out_data
);
  import fssc_pkg::*;

  // ==========================================================================
  // idle levels
  initial begin
    o_req_valid   = 1'b0;
    o_req_state   = 3'h0;
    o_mbx_cfg_ok  = 1'b0;
    o_pd_cfg_ok   = 1'b0;
    o_dc_used     = 1'b1;
    o_dc_cfg_ok   = 1'b0;
    o_frame_tick  = 1'b0;
    o_frame_seen  = 1'b0;
    o_pd_valid    = 1'b0;
    o_pd_out_data = 32'h0;
  end

  // ==========================================================================
  // state request: set up first, then a one-cycle request pulse
  // good[0] channel setup correct, good[1] clock setup correct
  task automatic request(input logic [2:0] st, input logic [1:0] good);
    @(negedge i_sys_clk);
    case (st)
      FSSC_REQ_PREOP, FSSC_REQ_BOOT: o_mbx_cfg_ok = good[0];
      FSSC_REQ_SAFE_OPERATIONAL_STATE: begin
        o_pd_cfg_ok = good[0];
        o_dc_cfg_ok = good[1];
      end
      FSSC_REQ_OP: o_pd_valid = 1'b1;
      default: ;
    endcase
    @(negedge i_sys_clk);
    o_req_valid = 1'b1;
    o_req_state = st;
    @(negedge i_sys_clk);
    o_req_valid = 1'b0;
    // released code lines flip so a stale value is never mistaken for a request
    o_req_state = ~st;
  endtask

  task automatic send_pd(input logic [FSSC_DATA_W-1:0] data);
    @(negedge i_sys_clk);
    o_pd_valid    = 1'b1;
    o_pd_out_data = data;
  endtask

  task automatic stop_pd();
    @(negedge i_sys_clk);
    o_pd_valid = 1'b0;
  endtask

  // distributed clocks in use or not; unused means its settings are ignored
  task automatic set_dc(input logic used);
    @(negedge i_sys_clk);
    o_dc_used = used;
  endtask

  // one bus cycle, telegram present or missing, closed by the boundary tick
  task automatic frame(input logic seen);
    @(negedge i_sys_clk);
    o_frame_seen = seen;
    repeat (2) @(negedge i_sys_clk);
    o_frame_tick = 1'b1;
    @(negedge i_sys_clk);
    o_frame_tick = 1'b0;
    o_frame_seen = 1'b0;
  endtask
endmodule // fssc_master_model

// ==== test/fssc_top_tb_top.sv ====
// fssc_top_tb_top: self-checking bench for the slave state control block
// assumes: fssc_master_model plays the master; jitter input quiet except one pulse in t_rerun
`timescale 1ns/100ps
module fssc_top_tb_top;
  import fssc_pkg::*;

  // ==========================================================================
  // nets
  logic                     i_sys_clk = 1'b0;
  logic                     i_rstn, i_req_valid, i_mbx_cfg_ok, i_pd_cfg_ok, i_dc_used, i_dc_cfg_ok;
  logic                     i_sync_done, i_frame_tick, i_frame_seen, i_jitter_err, i_wdog_disable;
  logic                     i_mbx_valid, i_pd_valid, i_fatal_err, i_nonfatal_err;
  logic [2:0]               i_req_state, i_layout_sel, o_layout;
  logic [1:0]               i_mbx_proto;
  logic [FSSC_DATA_W-1:0]   i_pd_out_data, i_in_data, o_in_buf_data, o_drive_out;
  logic [FSSC_POS_BITS-1:0] i_resolver_pos, o_position;
  logic [4:0]               o_state;
  logic [5:0]               o_err_code;
  logic                     o_ack, o_err, o_mbx_accept, o_pd_accept, o_in_wr, o_fatal_latched;
  logic                     o_nonfatal_latched;
  int                       n_fail = 0;
  int                       samples_checked = 0;
  int                       cycles = 0;

  always #4 i_sys_clk = ~i_sys_clk;

  fssc_top u_fssc_top (
    .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_req_valid(i_req_valid), .i_req_state(i_req_state),
    .i_mbx_cfg_ok(i_mbx_cfg_ok), .i_pd_cfg_ok(i_pd_cfg_ok), .i_dc_used(i_dc_used), .i_dc_cfg_ok(i_dc_cfg_ok),
    .i_sync_done(i_sync_done), .i_frame_tick(i_frame_tick), .i_frame_seen(i_frame_seen),
    .i_jitter_err(i_jitter_err), .i_wdog_disable(i_wdog_disable), .i_layout_sel(i_layout_sel),
    .i_mbx_valid(i_mbx_valid), .i_mbx_proto(i_mbx_proto), .i_pd_valid(i_pd_valid),
    .i_pd_out_data(i_pd_out_data), .i_in_data(i_in_data), .i_resolver_pos(i_resolver_pos),
    .i_fatal_err(i_fatal_err), .i_nonfatal_err(i_nonfatal_err), .o_state(o_state), .o_ack(o_ack),
    .o_err(o_err), .o_err_code(o_err_code), .o_mbx_accept(o_mbx_accept), .o_pd_accept(o_pd_accept),
    .o_in_wr(o_in_wr), .o_in_buf_data(o_in_buf_data), .o_position(o_position), .o_layout(o_layout),
    .o_drive_out(o_drive_out), .o_fatal_latched(o_fatal_latched), .o_nonfatal_latched(o_nonfatal_latched));

  fssc_master_model u_fssc_master_model (
    .i_sys_clk(i_sys_clk), .o_req_valid(i_req_valid), .o_req_state(i_req_state),
    .o_mbx_cfg_ok(i_mbx_cfg_ok), .o_pd_cfg_ok(i_pd_cfg_ok), .o_dc_used(i_dc_used),
    .o_dc_cfg_ok(i_dc_cfg_ok), .o_frame_tick(i_frame_tick), .o_frame_seen(i_frame_seen),
    .o_pd_valid(i_pd_valid), .o_pd_out_data(i_pd_out_data));

  // ==========================================================================
  // compare, verdict, hang guard
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 4000) begin
      n_fail++;
      results();
    end
  end

  // request, then judge the answer in the cycle where the ack stands
  task automatic step(input logic [2:0] st, input logic [1:0] good, input logic [4:0] nst,
                      input logic [5:0] code);
    u_fssc_master_model.request(st, good);
    check("state", o_state, nst);
    check("ack", o_ack, code == FSSC_ERR_NONE);
    if (code != FSSC_ERR_NONE) begin
      check("err_code", {o_err, o_err_code}, {1'b1, code});
    end
  endtask

  // ==========================================================================
  // scenarios
  task automatic do_reset();
    i_rstn = 1'b0;
    repeat (2) @(negedge i_sys_clk);
    i_rstn      = 1'b1;
    i_mbx_valid = 1'b1;
    #1;
    check("rst_state", o_state, FSSC_ST_INIT);
    check("init_mbx", o_mbx_accept, 1'b0);
    check("init_pd", o_pd_accept, 1'b0);
  endtask

  task automatic t_init_boot();
    u_fssc_master_model.send_pd(32'hA5A5_0F0F);
    step(FSSC_REQ_PREOP, 2'h0, FSSC_ST_INIT, FSSC_ERR_CONFIG);
    step(FSSC_REQ_BOOT, 2'h3, FSSC_ST_BOOT, FSSC_ERR_NONE);
    i_mbx_proto = FSSC_MBX_FILE;
    #1;
    check("boot_file", o_mbx_accept, 1'b1);
    i_mbx_proto = FSSC_MBX_SDO;
    #1;
    check("boot_sdo", o_mbx_accept, 1'b0);
    check("boot_pd", o_pd_accept, 1'b0);
    step(FSSC_REQ_INIT, 2'h3, FSSC_ST_INIT, FSSC_ERR_NONE);
    i_fatal_err    = 1'b1;
    i_nonfatal_err = 1'b1;
    @(negedge i_sys_clk);
    i_fatal_err    = 1'b0;
    i_nonfatal_err = 1'b0;
    check("nonfatal_set", o_nonfatal_latched, 1'b1);
    step(FSSC_REQ_PREOP, 2'h1, FSSC_ST_PREOP, FSSC_ERR_NONE);
    check("err_clear", o_err, 1'b0);
    check("fatal_kept", o_fatal_latched, 1'b1);
    check("nonfatal_clr", o_nonfatal_latched, 1'b0);
    #1;
    check("preop_mbx", o_mbx_accept, 1'b1);
    check("preop_pd", o_pd_accept, 1'b0);
    step(FSSC_REQ_BOOT, 2'h3, FSSC_ST_PREOP, FSSC_ERR_TRANS);
  endtask

  task automatic t_safe_operational_state();
    i_layout_sel = 3'h5;
    i_in_data    = 32'h1234_5678;
    step(FSSC_REQ_SAFE_OPERATIONAL_STATE, 2'h2, FSSC_ST_PREOP, FSSC_ERR_CONFIG);
    step(FSSC_REQ_SAFE_OPERATIONAL_STATE, 2'h1, FSSC_ST_PREOP, FSSC_ERR_CONFIG);
    step(FSSC_REQ_SAFE_OPERATIONAL_STATE, 2'h3, FSSC_ST_SAFE_OPERATIONAL_STATE, FSSC_ERR_NONE);
    check("layout", o_layout, 3'h5);
    check("in_copy", o_in_buf_data, 32'h1234_5678);
    check("in_wr", o_in_wr, 1'b1);
    #1;
    check("sop_pd", o_pd_accept, 1'b1);
    check("sop_mbx", o_mbx_accept, 1'b1);
    i_in_data = 32'h0BAD_F00D;
    // a full bus cycle passes, so either update cadence is covered
    u_fssc_master_model.frame(1'b1);
    check("in_upd", o_in_buf_data, 32'h0BAD_F00D);
    check("safe_out", o_drive_out, 32'h0);
    i_wdog_disable = 1'b1;
    repeat (2) @(negedge i_sys_clk);
    check("wd_off", o_drive_out, 32'hA5A5_0F0F);
    i_wdog_disable = 1'b0;
    repeat (2) @(negedge i_sys_clk);
    check("wd_on", o_drive_out, 32'h0);
  endtask

  task automatic t_op();
    step(FSSC_REQ_OP, 2'h3, FSSC_ST_SAFE_OPERATIONAL_STATE, FSSC_ERR_SYNC);
    i_sync_done = 1'b1;
    step(FSSC_REQ_OP, 2'h3, FSSC_ST_OP, FSSC_ERR_NONE);
    u_fssc_master_model.send_pd(32'hC3C3_3C3C);
    i_resolver_pos = 20'hABCDE;
    repeat (2) @(negedge i_sys_clk);
    check("op_out", o_drive_out, 32'hC3C3_3C3C);
    check("position", o_position, 20'hABCDE);
    check("op_pd", o_pd_accept, 1'b1);
    check("op_mbx", o_mbx_accept, 1'b1);
    u_fssc_master_model.frame(1'b0);
    u_fssc_master_model.frame(1'b1);
    u_fssc_master_model.frame(1'b0);
    check("one_miss", o_state, FSSC_ST_OP);
    u_fssc_master_model.frame(1'b0);
    @(negedge i_sys_clk);
    check("fallback", o_state, FSSC_ST_SAFE_OPERATIONAL_STATE);
    check("sync_code", {o_err, o_err_code}, {1'b1, FSSC_ERR_SYNC});
    check("fb_out", o_drive_out, 32'h0);
  endtask

  // after a mid-run reset: clock settings unused, idle offers, downward moves, jitter fallback
  task automatic t_rerun();
    step(FSSC_REQ_PREOP, 2'h1, FSSC_ST_PREOP, FSSC_ERR_NONE);
    i_mbx_valid = 1'b0;
    #1;
    check("mbx_idle", o_mbx_accept, 1'b0);
    i_mbx_valid = 1'b1;
    u_fssc_master_model.set_dc(1'b0);
    step(FSSC_REQ_SAFE_OPERATIONAL_STATE, 2'h1, FSSC_ST_SAFE_OPERATIONAL_STATE, FSSC_ERR_NONE);
    step(FSSC_REQ_OP, 2'h3, FSSC_ST_OP, FSSC_ERR_NONE);
    u_fssc_master_model.stop_pd();
    #1;
    check("pd_idle", o_pd_accept, 1'b0);
    step(FSSC_REQ_SAFE_OPERATIONAL_STATE, 2'h3, FSSC_ST_SAFE_OPERATIONAL_STATE, FSSC_ERR_NONE);
    step(FSSC_REQ_OP, 2'h3, FSSC_ST_OP, FSSC_ERR_NONE);
    i_jitter_err = 1'b1;
    @(negedge i_sys_clk);
    i_jitter_err = 1'b0;
    check("jit_state", o_state, FSSC_ST_SAFE_OPERATIONAL_STATE);
    check("jit_code", {o_err, o_err_code}, {1'b1, FSSC_ERR_SYNC});
    step(FSSC_REQ_INIT, 2'h3, FSSC_ST_INIT, FSSC_ERR_NONE);
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    i_rstn         = 1'b0;
    i_sync_done    = 1'b0;
    i_jitter_err   = 1'b0;
    i_wdog_disable = 1'b0;
    i_layout_sel   = 3'h0;
    i_mbx_valid    = 1'b0;
    i_mbx_proto    = FSSC_MBX_SDO;
    i_in_data      = 32'h0;
    i_resolver_pos = 20'h0;
    i_fatal_err    = 1'b0;
    i_nonfatal_err = 1'b0;
    do_reset();
    t_init_boot();
    t_safe_operational_state();
    t_op();
    do_reset();
    t_rerun();
    results();
  end
endmodule // fssc_top_tb_top
